// >>> design/uoim_defs.svh
// constants of the core interrupt status and mask block
// assumes a 32-bit classic wishbone slave, word aligned offsets
`ifndef UOIM_DEFS_SVH
`define UOIM_DEFS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define UOIM_OFS_CFG     8'h08
`define UOIM_OFS_STATUS  8'h14
`define UOIM_OFS_MASK    8'h18

// ************************************************************
// reset values
// ************************************************************
`define UOIM_MASK_RST    32'h0000_0000
`define UOIM_STATUS_RST  32'h0000_0000

// ************************************************************
// field positions
// ************************************************************
`define UOIM_B_ROLE    0
`define UOIM_B_ROLE_MISMATCH_FLAG    1
`define UOIM_B_PROT    2
`define UOIM_B_SOF     3
`define UOIM_B_RXF     4
`define UOIM_B_NPTX    5
`define UOIM_B_GINAK   6
`define UOIM_B_GONAK   7
`define UOIM_B_EARLY_IDLE_FLAG    10
`define UOIM_B_SUSP    11
`define UOIM_B_BRST    12
`define UOIM_B_ENUM    13
`define UOIM_B_ISOD    14
`define UOIM_B_PERIODIC_FRAME_END_FLAG    15
`define UOIM_B_IN_ENDPOINT_SUMMARY    18
`define UOIM_B_OUTEP   19
`define UOIM_B_IISO    20
`define UOIM_B_IPER    21
`define UOIM_B_HOST_PORT_CHANGE_SUMMARY   24
`define UOIM_B_HOST_CHANNEL_SUMMARY   25
`define UOIM_B_PTX     26
`define UOIM_B_CID     28
`define UOIM_B_DISC    29
`define UOIM_B_SESSION_REQUEST_FLAG    30
`define UOIM_B_WAKE    31
`define UOIM_B_GIE     0

// write-one-to-clear bits and valid mask bits
`define UOIM_W1C_BITS  32'hf030_fc0a
`define UOIM_MASK_BITS 32'hf73e_fcfe

// ************************************************************
// timing
// ************************************************************
`define UOIM_CLK_MHZ      250
`define UOIM_IDLE_MS      3
`define UOIM_IDLE_CYCLES  (`UOIM_IDLE_MS * 1000 * `UOIM_CLK_MHZ)

`endif

// >>> design/uoim_pkg.sv
// types of the core interrupt status and mask block
// assumes uoim_defs.svh is on the include path
`default_nettype none
package uoim_pkg;
  typedef enum logic [1:0] {UOIM_IDLE, UOIM_ACK} uoim_bus_type;
  typedef logic [31:0] uoim_word_type;
endpackage
`default_nettype wire

// >>> design/uoim_idle_timer.sv
// bus idle timer: raises a one-cycle pulse after a long idle stretch
// assumes idle_i is already synchronous to clk_i
`include "uoim_defs.svh"
`default_nettype none
module uoim_idle_timer
#(
  parameter int unsigned IDLE_CYCLES = `UOIM_IDLE_CYCLES
)
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // idle level and expiry pulse
  input  wire logic idle_i,
  output var  logic expired_o
);
  import uoim_pkg::*;

  typedef struct packed
  {
    logic [31:0] count;
    logic        done;
    logic        pulse;
  } uoim_timer_type;

  uoim_timer_type state_ff;
  uoim_timer_type nxt_state;

  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.pulse = 1'b0;
    if (!idle_i)
    begin
      nxt_state.count = 32'h0000_0000;
      nxt_state.done  = 1'b0;
    end
    else if (!state_ff.done)
    begin
      if (state_ff.count >= IDLE_CYCLES - 1)
      begin
        nxt_state.done  = 1'b1;
        nxt_state.pulse = 1'b1;
      end
      else
      begin
        nxt_state.count = state_ff.count + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign expired_o = state_ff.pulse;
endmodule
`default_nettype wire

// >>> design/uoim_core_irq.sv
// core interrupt status word, enable mask, global enable and irq line
// assumes event pulses and levels come from core logic on clk_i
//
// The Wishbone interface to the registers was decided locally.
`include "uoim_defs.svh"
`default_nettype none
module uoim_core_irq
#(
  parameter int unsigned IDLE_CYCLES = `UOIM_IDLE_CYCLES
)
(
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [7:0]            wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire uoim_pkg::uoim_word_type wb_dat_i,
  output var  uoim_pkg::uoim_word_type wb_dat_o,
  output var  logic                  wb_ack_o,
  // role and access checks
  input  wire logic                  host_role_i,
  input  wire logic                  wrong_role_access_i,
  // level sources
  input  wire logic                  protocol_event_pending_i,
  input  wire logic                  rx_fifo_pending_i,
  input  wire logic                  nonperiodic_tx_cond_i,
  input  wire logic                  nonperiodic_queue_space_i,
  input  wire logic                  global_in_nak_active_i,
  input  wire logic                  global_out_nak_active_i,
  input  wire logic                  in_endpoint_pending_i,
  input  wire logic                  out_endpoint_pending_i,
  input  wire logic                  host_port_change_i,
  input  wire logic                  host_channel_pending_i,
  input  wire logic                  periodic_tx_empty_i,
  input  wire logic                  periodic_queue_space_i,
  input  wire logic                  bus_idle_i,
  input  wire logic                  full_speed_i,
  // event pulses
  input  wire logic                  sof_event_i,
  input  wire logic                  bus_suspend_i,
  input  wire logic                  bus_reset_i,
  input  wire logic                  enum_done_i,
  input  wire logic                  iso_out_drop_i,
  input  wire logic                  frame_interval_i,
  input  wire logic                  iso_in_incomplete_i,
  input  wire logic                  periodic_incomplete_i,
  input  wire logic                  connector_id_change_i,
  input  wire logic                  disconnect_i,
  input  wire logic                  session_event_i,
  input  wire logic                  resume_wakeup_i,
  // interrupt line
  output var  logic                  irq_o
);
  import uoim_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed
  {
    uoim_bus_type  bus;
    uoim_word_type rdata;
    logic          ack;
    uoim_word_type sticky;
    uoim_word_type mask;
    logic          gie;
    logic          irq;
  } uoim_state_type;

  uoim_state_type state_ff;
  uoim_state_type nxt_state;
  logic           idle_expired;
  // ************************************************************
  // combinational words
  // ************************************************************
  uoim_word_type  live_any;
  uoim_word_type  live_host;
  uoim_word_type  live_dev;
  uoim_word_type  live;
  uoim_word_type  set_any;
  uoim_word_type  set_host;
  uoim_word_type  set_dev;
  uoim_word_type  set_ev;
  uoim_word_type  status;
  uoim_word_type  pending;
  uoim_word_type  wr_word;

  // ************************************************************
  // helpers
  // ************************************************************
  // byte-lane merge of write data
  function automatic uoim_word_type lane_merge(input uoim_word_type old,
                                               input uoim_word_type din,
                                               input logic [3:0] sel);
    uoim_word_type r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = din[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ************************************************************
  // role selection
  // ************************************************************
  function automatic uoim_word_type role_pick(input logic          host,
                                              input uoim_word_type h_word,
                                              input uoim_word_type p_word);
    uoim_word_type r;
    r = p_word;
    if (host)
    begin
      r = h_word;
    end
    return r;
  endfunction

  // ************************************************************
  // read data
  // ************************************************************
  function automatic uoim_word_type read_word(input logic [7:0]    adr,
                                              input uoim_word_type stat,
                                              input uoim_word_type msk,
                                              input logic          en);
    uoim_word_type r;
    r = 32'h0000_0000;
    case (adr)
      `UOIM_OFS_STATUS:
      begin
        r = stat;
      end
      `UOIM_OFS_MASK:
      begin
        r = msk;
      end
      `UOIM_OFS_CFG:
      begin
        r = {31'h0000_0000, en};
      end
      default:
      begin
        r = 32'h0000_0000;
      end
    endcase
    return r;
  endfunction

  // ************************************************************
  // idle timer
  // ************************************************************
  uoim_idle_timer #(
    .IDLE_CYCLES (IDLE_CYCLES)
  ) u_idle (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .idle_i    (bus_idle_i & ~host_role_i),
    .expired_o (idle_expired)
  );

  // ************************************************************
  // levels seen in either role
  // ************************************************************
  always_comb
  begin
    live_any = 32'h0000_0000;
    live_any[`UOIM_B_ROLE] = host_role_i;
    live_any[`UOIM_B_PROT] = protocol_event_pending_i;
    live_any[`UOIM_B_RXF]  = rx_fifo_pending_i;
  end

  // ************************************************************
  // levels seen in host role only
  // ************************************************************
  always_comb
  begin
    live_host = 32'h0000_0000;
    live_host[`UOIM_B_NPTX]  = nonperiodic_tx_cond_i & nonperiodic_queue_space_i;
    live_host[`UOIM_B_HOST_PORT_CHANGE_SUMMARY] = host_port_change_i;
    live_host[`UOIM_B_HOST_CHANNEL_SUMMARY] = host_channel_pending_i;
    live_host[`UOIM_B_PTX]   = periodic_tx_empty_i & periodic_queue_space_i;
  end

  // ************************************************************
  // levels seen in peripheral role only
  // ************************************************************
  always_comb
  begin
    live_dev = 32'h0000_0000;
    live_dev[`UOIM_B_GINAK] = global_in_nak_active_i;
    live_dev[`UOIM_B_GONAK] = global_out_nak_active_i;
    live_dev[`UOIM_B_IN_ENDPOINT_SUMMARY]  = in_endpoint_pending_i;
    live_dev[`UOIM_B_OUTEP] = out_endpoint_pending_i;
  end

  assign live = live_any | role_pick(host_role_i, live_host, live_dev);

  // ************************************************************
  // events seen in either role
  // ************************************************************
  always_comb
  begin
    set_any = 32'h0000_0000;
    set_any[`UOIM_B_ROLE_MISMATCH_FLAG] = wrong_role_access_i;
    set_any[`UOIM_B_CID]  = connector_id_change_i;
    set_any[`UOIM_B_DISC] = disconnect_i;
    set_any[`UOIM_B_SESSION_REQUEST_FLAG] = session_event_i;
    set_any[`UOIM_B_WAKE] = resume_wakeup_i;
  end

  // ************************************************************
  // events seen in host role only
  // ************************************************************
  always_comb
  begin
    set_host = 32'h0000_0000;
    set_host[`UOIM_B_SOF]  = sof_event_i;
    set_host[`UOIM_B_IPER] = periodic_incomplete_i;
  end

  // ************************************************************
  // events seen in peripheral role only
  // ************************************************************
  always_comb
  begin
    set_dev = 32'h0000_0000;
    set_dev[`UOIM_B_SOF]  = sof_event_i & full_speed_i;
    set_dev[`UOIM_B_EARLY_IDLE_FLAG] = idle_expired;
    set_dev[`UOIM_B_SUSP] = bus_suspend_i;
    set_dev[`UOIM_B_BRST] = bus_reset_i;
    set_dev[`UOIM_B_ENUM] = enum_done_i;
    set_dev[`UOIM_B_ISOD] = iso_out_drop_i;
    set_dev[`UOIM_B_PERIODIC_FRAME_END_FLAG] = frame_interval_i;
    set_dev[`UOIM_B_IISO] = frame_interval_i & iso_in_incomplete_i;
    set_dev[`UOIM_B_IPER] = frame_interval_i & periodic_incomplete_i;
  end

  assign set_ev = set_any | role_pick(host_role_i, set_host, set_dev);
  assign status = (state_ff.sticky & `UOIM_W1C_BITS) | live;

  // ************************************************************
  // combined interrupt
  // ************************************************************
  assign pending = status & state_ff.mask;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    nxt_state     = state_ff;
    nxt_state.ack = 1'b0;
    wr_word       = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);
    case (state_ff.bus)
      UOIM_IDLE:
      begin
        if (wb_cyc_i && wb_stb_i)
        begin
          nxt_state.ack = 1'b1;
          nxt_state.bus = UOIM_ACK;
          nxt_state.rdata = read_word(wb_adr_i, status, state_ff.mask, state_ff.gie);
          case (wb_adr_i)
            `UOIM_OFS_STATUS:
            begin
              if (wb_we_i)
              begin
                nxt_state.sticky = state_ff.sticky & ~(wr_word & `UOIM_W1C_BITS);
              end
            end
            `UOIM_OFS_MASK:
            begin
              if (wb_we_i)
              begin
                nxt_state.mask = lane_merge(state_ff.mask, wb_dat_i, wb_sel_i)
                                 & `UOIM_MASK_BITS;
              end
            end
            `UOIM_OFS_CFG:
            begin
              if (wb_we_i && wb_sel_i[0])
              begin
                nxt_state.gie = wb_dat_i[`UOIM_B_GIE];
              end
            end
            default:
            begin
              nxt_state.rdata = 32'h0000_0000;
            end
          endcase
        end
      end
      UOIM_ACK:
      begin
        nxt_state.bus = UOIM_IDLE;
      end
      default:
      begin
        nxt_state.bus = UOIM_IDLE;
      end
    endcase
    // set wins over a same-cycle clear; status sets whatever the mask
    nxt_state.sticky = (nxt_state.sticky | set_ev) & `UOIM_W1C_BITS;
    nxt_state.irq = state_ff.gie & (|pending);
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff.bus    <= UOIM_IDLE;
      state_ff.rdata  <= 32'h0000_0000;
      state_ff.ack    <= 1'b0;
      state_ff.sticky <= `UOIM_STATUS_RST;
      state_ff.mask   <= `UOIM_MASK_RST;
      state_ff.gie    <= 1'b0;
      state_ff.irq    <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign wb_dat_o = state_ff.rdata;
  assign wb_ack_o = state_ff.ack;
  assign irq_o    = state_ff.irq;
endmodule
`default_nettype wire

// >>> dv/uoim_core_irq_checker.sv
// assertions on the ports of the core interrupt status and mask block
// assumes one clock domain and a bind to every uoim_core_irq instance
`include "uoim_defs.svh"
`default_nettype none
module uoim_core_irq_checker
#(
  parameter int unsigned IDLE_CYCLES = 20
)
(
  // clock and reset
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  // wishbone
  input wire logic                    wb_cyc_i,
  input wire logic                    wb_stb_i,
  input wire logic                    wb_we_i,
  input wire logic [7:0]              wb_adr_i,
  input wire uoim_pkg::uoim_word_type wb_dat_o,
  input wire logic                    wb_ack_o,
  // sources and line
  input wire logic                    host_role_i,
  input wire logic                    rx_fifo_pending_i,
  input wire logic                    irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import uoim_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd_ack;
  logic rd_stat;
  assign rd_ack = wb_ack_o && !wb_we_i;
  assign rd_stat = rd_ack && wb_adr_i == `UOIM_OFS_STATUS;
  // ************************************************************
  // bus answer
  // ************************************************************
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held past one cycle");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o)
    else $error("outputs active right after reset");
  // ************************************************************
  // read data
  // ************************************************************
  a_role_read: assert property (rd_stat |-> wb_dat_o[0] == $past(host_role_i))
    else $error("role bit differs from role input");
  a_rxf_read: assert property (rd_stat |-> wb_dat_o[4] == $past(rx_fifo_pending_i))
    else $error("fifo bit differs from fifo input");
  a_status_rsvd: assert property (rd_stat |-> (wb_dat_o & 32'h08c3_0300) == 32'h0)
    else $error("reserved status bit set");
  a_mask_rsvd: assert property (rd_ack && wb_adr_i == `UOIM_OFS_MASK
    |-> (wb_dat_o & ~`UOIM_MASK_BITS) == 32'h0)
    else $error("reserved mask bit set");
  a_unmapped_zero: assert property (rd_ack && wb_adr_i != `UOIM_OFS_MASK
    && wb_adr_i != `UOIM_OFS_STATUS && wb_adr_i != `UOIM_OFS_CFG |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule
bind uoim_core_irq uoim_core_irq_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk
(
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .host_role_i(host_role_i), .rx_fifo_pending_i(rx_fifo_pending_i), .irq_o(irq_o)
);
`default_nettype wire

// >>> dv/uoim_src_model.sv
// event source model: core levels, event pulses, role and access checks
// assumes its tasks are called from a process of the clk_i domain
`default_nettype none
module uoim_src_model
(
  // clock
  input  wire logic        clk_i,
  // levels and pulses toward the block
  output var  logic [14:0] lvl_o,
  output var  logic [12:0] pls_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lvl_o = '0;
  initial pls_o = '0;
  // level stays until the next set_lvl call replaces it
  task automatic set_lvl(input logic [14:0] v);
    @(posedge clk_i);
    lvl_o <= v;
  endtask
  // one-cycle pulse, qualifiers ride with the frame point
  task automatic fire(input logic [12:0] m);
    @(posedge clk_i);
    pls_o <= m;
    @(posedge clk_i);
    pls_o <= '0;
  endtask
endmodule
`default_nettype wire

// >>> dv/uoim_core_irq_bench.sv
// self-checking bench of the core interrupt status and mask block
// assumes uoim_defs.svh on the include path and the source model beside it
`include "uoim_defs.svh"
`default_nettype none
module uoim_core_irq_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uoim_pkg::*;
  localparam int unsigned IDLE = 20;
  logic          clk_i, rst_i, cyc, stb, we, ack, irq;
  logic [7:0]    adr;
  logic [3:0]    sel;
  uoim_word_type dat_w, dat_r, r;
  logic [14:0]   lvl;
  logic [12:0]   pls;
  logic [32:0]   note;
  logic [32:0]   notes[$];
  int            n_fail, n_tests;
  logic [59:0]   rows [22] = '{
    {15'h2000, 13'h0001, 32'h0000_0008}, {15'h2000, 13'h0002, 32'h0000_0800},
    {15'h2000, 13'h0004, 32'h0000_1000}, {15'h2000, 13'h0008, 32'h0000_2000},
    {15'h2000, 13'h0010, 32'h0000_4000}, {15'h2000, 13'h0020, 32'h0000_8000},
    {15'h2000, 13'h0060, 32'h0010_8000}, {15'h2000, 13'h00a0, 32'h0020_8000},
    {15'h2000, 13'h0100, 32'h1000_0000}, {15'h2000, 13'h0200, 32'h2000_0000},
    {15'h2000, 13'h0400, 32'h4000_0000}, {15'h2000, 13'h0800, 32'h8000_0000},
    {15'h2000, 13'h1000, 32'h0000_0002}, {15'h0000, 13'h0001, 32'h0000_0000},
    {15'h4000, 13'h0001, 32'h0000_0009}, {15'h4000, 13'h0080, 32'h0020_0001},
    {15'h4000, 13'h0800, 32'h8000_0001}, {15'h2fff, 13'h0000, 32'h000c_00d4},
    {15'h6fff, 13'h0000, 32'h0700_0035}, {15'h6ff7, 13'h0000, 32'h0700_0015},
    {15'h67f7, 13'h0000, 32'h0300_0015}, {15'h0000, 13'h0000, 32'h0000_0000}};
  uoim_src_model src (.clk_i(clk_i), .lvl_o(lvl), .pls_o(pls));
  uoim_core_irq #(.IDLE_CYCLES(IDLE)) dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
    .host_role_i(lvl[14]), .wrong_role_access_i(pls[12]), .protocol_event_pending_i(lvl[0]),
    .rx_fifo_pending_i(lvl[1]), .nonperiodic_tx_cond_i(lvl[2]),
    .nonperiodic_queue_space_i(lvl[3]), .global_in_nak_active_i(lvl[4]),
    .global_out_nak_active_i(lvl[5]), .in_endpoint_pending_i(lvl[6]),
    .out_endpoint_pending_i(lvl[7]), .host_port_change_i(lvl[8]),
    .host_channel_pending_i(lvl[9]), .periodic_tx_empty_i(lvl[10]),
    .periodic_queue_space_i(lvl[11]), .bus_idle_i(lvl[12]), .full_speed_i(lvl[13]),
    .sof_event_i(pls[0]), .bus_suspend_i(pls[1]), .bus_reset_i(pls[2]), .enum_done_i(pls[3]),
    .iso_out_drop_i(pls[4]), .frame_interval_i(pls[5]), .iso_in_incomplete_i(pls[6]),
    .periodic_incomplete_i(pls[7]), .connector_id_change_i(pls[8]), .disconnect_i(pls[9]),
    .session_event_i(pls[10]), .resume_wakeup_i(pls[11]), .irq_o(irq)
  );
  // ************************************************************
  // clock, compare and bus tasks
  // ************************************************************
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input uoim_word_type e, input uoim_word_type g);
    n_tests++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  always @(posedge clk_i)
  begin
    if (ack === 1'b1)
    begin
      note = notes.pop_front();
      if (note[32])
        chk("read data", note[31:0], dat_r);
    end
  end
  task automatic bus(input logic w, input logic [7:0] a, input uoim_word_type d,
                     input logic c, input uoim_word_type e);
    int t;
    t = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= d;
    notes.push_back({c, e});
    do
    begin
      @(posedge clk_i);
      t++;
    end
    while (ack !== 1'b1 && t < 50);
    if (ack !== 1'b1)
    begin
      n_fail++;
      wrap_up();
    end
    else
    begin
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, input uoim_word_type e);
    bus(1'b0, a, '0, 1'b1, e);
  endtask
  task automatic wr(input logic [7:0] a, input uoim_word_type d);
    bus(1'b1, a, d, 1'b0, '0);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk_i);
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    wrap_up();
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    void'($urandom(78801));
    rst_i = 1'b1;
    {cyc, stb, we, adr, dat_w} = '0;
    sel = 4'hf;
    n_fail = 0;
    n_tests = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`UOIM_OFS_MASK, `UOIM_MASK_RST);
    rd(`UOIM_OFS_STATUS, `UOIM_STATUS_RST);
    rd(`UOIM_OFS_CFG, 32'h0);
    wr(8'h40, $urandom);
    rd(8'h40, 32'h0);
    wr(`UOIM_OFS_STATUS, 32'hffff_ffff);
    wr(`UOIM_OFS_MASK, 32'hffff_ffff);
    rd(`UOIM_OFS_MASK, `UOIM_MASK_BITS);
    wr(`UOIM_OFS_CFG, 32'h1);
    foreach (rows[i])
    begin
      src.set_lvl(rows[i][59:45]);
      src.fire(rows[i][44:32]);
      rd(`UOIM_OFS_STATUS, rows[i][31:0]);
      irq_is(|(rows[i][31:0] & `UOIM_MASK_BITS));
      wr(`UOIM_OFS_STATUS, rows[i][31:0]);
      rd(`UOIM_OFS_STATUS, rows[i][31:0] & ~`UOIM_W1C_BITS);
    end
    src.set_lvl(15'h3000);
    repeat (IDLE + 5) @(posedge clk_i);
    rd(`UOIM_OFS_STATUS, 32'h0000_0400);
    wr(`UOIM_OFS_STATUS, 32'h0000_0400);
    repeat (IDLE + 5) @(posedge clk_i);
    rd(`UOIM_OFS_STATUS, 32'h0);
    src.set_lvl(15'h2000);
    for (int k = 0; k < 4; k++)
    begin
      r = {k[0], 31'($urandom)};
      wr(`UOIM_OFS_MASK, r);
      src.fire(13'h0800);
      rd(`UOIM_OFS_STATUS, 32'h8000_0000);
      irq_is(r[31]);
      wr(`UOIM_OFS_CFG, 32'h0);
      irq_is(1'b0);
      wr(`UOIM_OFS_CFG, 32'h1);
      wr(`UOIM_OFS_STATUS, 32'h8000_0000);
    end
    sel <= 4'h8;
    wr(`UOIM_OFS_MASK, 32'h0);
    rd(`UOIM_OFS_MASK, {8'h00, r[23:0]} & `UOIM_MASK_BITS);
    sel <= 4'hf;
    wrap_up();
  end
endmodule
`default_nettype wire
